// file: design/gdio_pkg.sv
// Register map, field positions and reset values of the digital I/O port
package gdio_pkg;
	localparam int GDIO_PINS = 8;
	localparam int GDIO_ADR_W = 8;
	localparam int GDIO_DAT_W = 32;
	localparam int GDIO_SEL_W = GDIO_DAT_W / 8;
	localparam logic [GDIO_ADR_W-1:0] OFS_DIRECTION = 8'h00;
	localparam logic [GDIO_ADR_W-1:0] OFS_OUTPUT = 8'h04;
	localparam logic [GDIO_ADR_W-1:0] OFS_INPUT = 8'h08;
	localparam logic [GDIO_ADR_W-1:0] OFS_CONTROL = 8'h0c;
	localparam logic [GDIO_ADR_W-1:0] OFS_WAKE_FLAG = 8'h10;
	localparam int CTRL_PUD_BIT = 0;
	localparam int LANE_LOW = 0;
	localparam logic [GDIO_PINS-1:0] RST_DIRECTION = 8'h00;
	localparam logic [GDIO_PINS-1:0] RST_OUTPUT = 8'h00;
	localparam logic RST_PUD = 1'b0;
	localparam logic [1:0] WAKE_SETTLE = 2'h2;
	localparam logic [1:0] WAKE_CHECK = 2'h1;
	localparam logic [1:0] WAKE_IDLE = 2'h0;
endpackage : gdio_pkg

// file: design/gdio_sync.sv
// Latch-then-flop input synchroniser, one lane per pin
`timescale 1ns/1ps
`default_nettype none
module gdio_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Pin levels and synchronised sample
	input wire logic [WIDTH-1:0] padIn,
	output logic [WIDTH-1:0] sampleOut
);
	logic [WIDTH-1:0] syncLatch;

	always_latch begin
		if (core_clk) begin
			// Flop must see the value held before the edge
			syncLatch <= padIn;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sampleOut <= '0;
		end else begin
			sampleOut <= syncLatch;
		end
	end
endmodule : gdio_sync
`default_nettype wire

// file: design/gdio_wake.sv
// Wake flags raised when a sleep clamp releases on a high pin
`timescale 1ns/1ps
`default_nettype none
module gdio_wake
	import gdio_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Pin state
	input wire logic [WIDTH-1:0] clampActive,
	input wire logic [WIDTH-1:0] sampleIn,
	input wire logic [WIDTH-1:0] edgeSense,
	// Write-one-to-clear
	input wire logic [WIDTH-1:0] clearMask,
	output logic [WIDTH-1:0] wakeFlag
);
	genvar n;
	generate
		for (n = 0; n < WIDTH; n++) begin : g_pin
			logic [1:0] settle;
			logic setNow;
			// Wait for the released level to pass the synchroniser
			always_ff @(posedge core_clk) begin
				if (srst) begin
					settle <= WAKE_IDLE;
				end else if (clampActive[n]) begin
					settle <= WAKE_SETTLE;
				end else if (settle != WAKE_IDLE) begin
					settle <= settle - WAKE_CHECK;
				end
			end
			// high level after clamp sets flag
			assign setNow = (settle == WAKE_CHECK) && sampleIn[n] && edgeSense[n];
			// Set wins over a clear in the same cycle
			always_ff @(posedge core_clk) begin
				if (srst) begin
					wakeFlag[n] <= 1'b0;
				end else if (setNow) begin
					wakeFlag[n] <= 1'b1;
				end else if (clearMask[n]) begin
					wakeFlag[n] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : gdio_wake
`default_nettype wire

// file: design/gdio_port.sv
// General digital I/O port with a classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module gdio_port
	import gdio_pkg::*;
#(
	parameter int PINS = GDIO_PINS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Wishbone classic slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [GDIO_ADR_W-1:0] wbAdr,
	input wire logic [GDIO_SEL_W-1:0] wbSel,
	input wire logic [GDIO_DAT_W-1:0] wbDatIn,
	output logic [GDIO_DAT_W-1:0] wbDatOut,
	output logic wbAck,
	// Pads
	input wire logic [PINS-1:0] pinIn,
	output logic [PINS-1:0] pinOut,
	output logic [PINS-1:0] pinOe,
	output logic [PINS-1:0] pinPullUp,
	// Sleep controller and external interrupt unit
	input wire logic sleepClamp,
	input wire logic [PINS-1:0] extIntEnable,
	input wire logic [PINS-1:0] extIntEdgeSense,
	output logic [PINS-1:0] wakeFlag,
	// Synchronised pin levels for other logic
	output logic [PINS-1:0] pinSample
);
	logic [PINS-1:0] directionReg;
	logic [PINS-1:0] outputReg;
	logic pullupGlobalDisable;
	logic [PINS-1:0] digitalIn;
	logic [PINS-1:0] clampActive;
	logic [PINS-1:0] inputSample;
	logic [PINS-1:0] wakeClear;
	logic [PINS-1:0] oeHold;
	logic [PINS-1:0] pullHold;
	logic takeReq;
	logic writeLow;
	logic [PINS-1:0] wrByte;
	logic [GDIO_DAT_W-1:0] next_datOut;

	// One request per ack; the ack cycle itself is not re-taken
	assign takeReq = wbCyc && wbStb && !wbAck;
	assign writeLow = takeReq && wbWe && wbSel[LANE_LOW];
	assign wrByte = wbDatIn[PINS-1:0];

	// Bus answer one cycle after the request
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wbAck <= 1'b0;
		end else begin
			wbAck <= takeReq;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			directionReg <= RST_DIRECTION;
		end else if (writeLow && wbAdr == OFS_DIRECTION) begin
			directionReg <= wrByte;
		end
	end

	// write or toggle of output value
	always_ff @(posedge core_clk) begin
		if (srst) begin
			outputReg <= RST_OUTPUT;
		end else if (writeLow && wbAdr == OFS_OUTPUT) begin
			outputReg <= wrByte;
		end else if (writeLow && wbAdr == OFS_INPUT) begin
			outputReg <= outputReg ^ wrByte;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pullupGlobalDisable <= RST_PUD;
		end else if (writeLow && wbAdr == OFS_CONTROL) begin
			pullupGlobalDisable <= wbDatIn[CTRL_PUD_BIT];
		end
	end

	assign wakeClear = (writeLow && wbAdr == OFS_WAKE_FLAG) ? wrByte : '0;

	// read mux; input register shows pins
	always_comb begin
		next_datOut = '0;
		unique case (wbAdr)
			OFS_DIRECTION: next_datOut[PINS-1:0] = directionReg;
			OFS_OUTPUT: next_datOut[PINS-1:0] = outputReg;
			OFS_INPUT: next_datOut[PINS-1:0] = inputSample;
			OFS_CONTROL: next_datOut[CTRL_PUD_BIT] = pullupGlobalDisable;
			OFS_WAKE_FLAG: next_datOut[PINS-1:0] = wakeFlag;
			default: next_datOut = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wbDatOut <= '0;
		end else if (takeReq && !wbWe) begin
			wbDatOut <= next_datOut;
		end
	end

	// Pad controls held in flops, reset gates enable and pull-up below
	always_ff @(posedge core_clk) begin
		if (srst) begin
			oeHold <= '0;
			pullHold <= '0;
			pinOut <= RST_OUTPUT;
		end else begin
			// drive value, never pull on output
			oeHold <= next_oe();
			pullHold <= next_pull();
			pinOut <= next_out();
		end
	end

	function automatic logic [PINS-1:0] next_oe();
		if (writeLow && wbAdr == OFS_DIRECTION) begin
			return wrByte;
		end
		return directionReg;
	endfunction : next_oe

	function automatic logic [PINS-1:0] next_out();
		if (writeLow && wbAdr == OFS_OUTPUT) begin
			return wrByte;
		end
		if (writeLow && wbAdr == OFS_INPUT) begin
			return outputReg ^ wrByte;
		end
		return outputReg;
	endfunction : next_out

	function automatic logic [PINS-1:0] next_pull();
		logic pullup_global_disable;
		pullup_global_disable = pullupGlobalDisable;
		if (writeLow && wbAdr == OFS_CONTROL) begin
			pullup_global_disable = wbDatIn[CTRL_PUD_BIT];
		end
		// pull-up for input with value one
		return ~next_oe() & next_out() & {PINS{~pullup_global_disable}};
	endfunction : next_pull

	// tri-state under reset, no clock needed
	assign pinOe = oeHold & {PINS{~srst}};
	assign pinPullUp = pullHold & {PINS{~srst}};

	assign clampActive = {PINS{sleepClamp}} & ~extIntEnable;
	// clamp ahead of the input path
	assign digitalIn = pinIn & ~clampActive;

	// driven value reaches sampler next cycle
	gdio_sync #(
		.WIDTH(PINS)
	) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.padIn(digitalIn),
		.sampleOut(inputSample)
	);

	assign pinSample = inputSample;

	gdio_wake #(
		.WIDTH(PINS)
	) u_wake (
		.core_clk(core_clk),
		.srst(srst),
		.clampActive(clampActive),
		.sampleIn(inputSample),
		.edgeSense(extIntEdgeSense),
		.clearMask(wakeClear),
		.wakeFlag(wakeFlag)
	);

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	property p_dirWrite;
		(writeLow && wbAdr == OFS_DIRECTION) |=> (pinOe == $past(wrByte));
	endproperty
	a_dirWrite: assert property (p_dirWrite)
		else $error("direction write not seen on output enable");

	property p_pullUp;
		pinPullUp == (~pinOe & pinOut & {PINS{!pullupGlobalDisable}});
	endproperty
	a_pullUp: assert property (p_pullUp)
		else $error("input pin with value one lacks pull-up");

	property p_pudOff;
		pullupGlobalDisable |-> (pinPullUp == '0);
	endproperty
	a_pudOff: assert property (p_pudOff)
		else $error("pull-up active while globally disabled");

	property p_noPullOnOut;
		(pinPullUp & pinOe) == '0;
	endproperty
	a_noPullOnOut: assert property (p_noPullOnOut)
		else $error("pull-up on a driven pin");

	property p_toggle;
		(writeLow && wbAdr == OFS_INPUT) |=>
			(pinOut == ($past(outputReg) ^ $past(wrByte)));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("input write did not toggle output");

	property p_clamp;
		sleepClamp |-> ((digitalIn & ~extIntEnable) == '0);
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("digital input not clamped in sleep");

	property p_inputRead;
		(takeReq && !wbWe && wbAdr == OFS_INPUT) |=>
			(wbAck && wbDatOut[PINS-1:0] == $past(inputSample));
	endproperty
	a_inputRead: assert property (p_inputRead)
		else $error("input register read wrong value");

	property p_inputReadOnly;
		(writeLow && wbAdr == OFS_INPUT) |=> $stable(directionReg);
	endproperty
	a_inputReadOnly: assert property (p_inputReadOnly)
		else $error("input write disturbed direction");

	property p_ackPulse;
		wbAck |=> !wbAck;
	endproperty
	a_ackPulse: assert property (p_ackPulse)
		else $error("ack held for more than one cycle");

	property p_ackAnswer;
		takeReq |=> wbAck;
	endproperty
	a_ackAnswer: assert property (p_ackAnswer)
		else $error("request not answered in the next cycle");

	property p_ackOnly;
		wbAck |-> $past(takeReq);
	endproperty
	a_ackOnly: assert property (p_ackOnly)
		else $error("ack without a taken request");

	property p_outWrite;
		(writeLow && wbAdr == OFS_OUTPUT) |=> (pinOut == $past(wrByte));
	endproperty
	a_outWrite: assert property (p_outWrite)
		else $error("output write not seen on pin value");

	property p_outStable;
		!(writeLow && (wbAdr == OFS_OUTPUT || wbAdr == OFS_INPUT)) |=>
			$stable(pinOut);
	endproperty
	a_outStable: assert property (p_outStable)
		else $error("pin value changed without a write");

	property p_dirStable;
		!(writeLow && wbAdr == OFS_DIRECTION) |=> $stable(pinOe);
	endproperty
	a_dirStable: assert property (p_dirStable)
		else $error("output enable changed without a write");

	property p_pudSet;
		(writeLow && wbAdr == OFS_CONTROL && wbDatIn[CTRL_PUD_BIT]) |=>
			pullupGlobalDisable;
	endproperty
	a_pudSet: assert property (p_pudSet)
		else $error("pull-up disable bit not stored");

	property p_resetTri;
		disable iff (1'b0) srst |-> (pinOe == '0);
	endproperty
	a_resetTri: assert property (p_resetTri)
		else $error("pin driven while reset is high");

	property p_resetPull;
		disable iff (1'b0) srst |-> (pinPullUp == '0);
	endproperty
	a_resetPull: assert property (p_resetPull)
		else $error("pull-up on while reset is high");

	property p_dirRead;
		(takeReq && !wbWe && wbAdr == OFS_DIRECTION) |=>
			(wbDatOut[PINS-1:0] == $past(directionReg));
	endproperty
	a_dirRead: assert property (p_dirRead)
		else $error("direction register read wrong value");

	property p_outRead;
		(takeReq && !wbWe && wbAdr == OFS_OUTPUT) |=>
			(wbDatOut[PINS-1:0] == $past(outputReg));
	endproperty
	a_outRead: assert property (p_outRead)
		else $error("output register read wrong value");

	property p_wakeHold;
		!$past(srst) |->
			(($past(wakeFlag) & ~$past(wakeClear) & ~wakeFlag) == '0);
	endproperty
	a_wakeHold: assert property (p_wakeHold)
		else $error("wake flag lost without a clear");

	c_toggle: cover property ((writeLow && wbAdr == OFS_INPUT) ##1 pinOut != $past(pinOut));
	c_outputHigh: cover property (pinOe[0] && pinOut[0]);
	c_wake: cover property ($rose(wakeFlag[0]));
	c_sleep: cover property (sleepClamp ##1 !sleepClamp);
	c_pudOff: cover property (pullupGlobalDisable && pinOe != '0);
endmodule : gdio_port
`default_nettype wire

// file: sim/gdio_pad_model.sv
// Pad and external circuit model resolving each pin level
`timescale 1ns/1ps
`default_nettype none
module gdio_pad_model (
	// Clock
	input wire logic core_clk,
	// Port side
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic [7:0] pinPullUp,
	// External drivers
	input wire logic [7:0] extEn,
	input wire logic [7:0] extVal,
	// Resolved pad level
	output logic [7:0] padLevel
);
	logic [7:0] floatVal = 8'h00;

	// Undriven pins wander so a float never reads as a clean level
	always_ff @(posedge core_clk) begin
		floatVal <= ~padLevel;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pinOe[i])
				padLevel[i] = pinOut[i];
			else if (extEn[i])
				padLevel[i] = extVal[i];
			else if (pinPullUp[i])
				padLevel[i] = 1'b1;
			else
				padLevel[i] = floatVal[i];
		end
	end
endmodule : gdio_pad_model
`default_nettype wire

// file: sim/tb_top.sv
// Register-level regression of the digital I/O port
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import gdio_pkg::*;
;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [GDIO_ADR_W-1:0] wbAdr = 8'h00;
	logic [GDIO_SEL_W-1:0] wbSel = 4'h1;
	logic [GDIO_DAT_W-1:0] wbDatIn = 32'h0;
	logic [GDIO_DAT_W-1:0] wbDatOut;
	logic wbAck;
	logic [7:0] pinIn, pinOut, pinOe, pinPullUp, wakeFlag, pinSample;
	logic sleepClamp = 1'b0;
	logic [7:0] extIntEnable = 8'h00;
	logic [7:0] extIntEdgeSense = 8'h00;
	logic [7:0] extEn = 8'hff;
	logic [7:0] extVal = 8'h5a;
	logic [31:0] rd;
	int num_errors = 0;
	int n_checks = 0;

	always #50 core_clk = ~core_clk;

	gdio_port #(.PINS(GDIO_PINS)) u_gdio_port (.core_clk(core_clk),
		.srst(srst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
		.wbDatOut(wbDatOut), .wbAck(wbAck), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp),
		.sleepClamp(sleepClamp), .extIntEnable(extIntEnable),
		.extIntEdgeSense(extIntEdgeSense), .wakeFlag(wakeFlag),
		.pinSample(pinSample));

	gdio_pad_model u_gdio_pad_model (.core_clk(core_clk),
		.pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp),
		.extEn(extEn), .extVal(extVal), .padLevel(pinIn));

	task results;
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One classic cycle, held until ack is sampled high
	task wbXfer(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbDatIn <= dat;
		do begin
			@(posedge core_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			results();
		end
		rd = wbDatOut;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask : wbXfer

	task wrReg(input logic [7:0] adr, input logic [31:0] dat);
		wbXfer(1'b1, adr, dat);
	endtask : wrReg

	task rdChk(input logic [7:0] adr, input logic [31:0] exp);
		wbXfer(1'b0, adr, 32'h0);
		check(rd, exp);
	endtask : rdChk

	initial begin
		#200000;
		num_errors++;
		results();
	end

	initial begin
		repeat (16) @(posedge core_clk);
		#1;
		check({16'h0, pinOe, pinPullUp}, 32'h0);
		@(posedge core_clk);
		srst <= 1'b0;
		rdChk(OFS_INPUT, 32'h5a);
		rdChk(OFS_DIRECTION, 32'h0);
		wrReg(OFS_OUTPUT, 32'hf0);
		wrReg(OFS_DIRECTION, 32'h0f); // From tri-state to output low
		check({8'h0, pinOe, pinPullUp, pinOut & pinOe}, 32'h0ff000);
		extEn <= 8'h30;
		rdChk(OFS_INPUT, 32'hd0);
		wrReg(OFS_OUTPUT, 32'hff);
		rdChk(OFS_INPUT, 32'hdf);
		extEn <= 8'hf0;
		wrReg(OFS_CONTROL, 32'h1);
		check({24'h0, pinPullUp}, 32'h0);
		rdChk(OFS_OUTPUT, 32'hff);
		wrReg(OFS_CONTROL, 32'h0);
		check({24'h0, pinPullUp}, 32'hf0);
		wrReg(OFS_INPUT, 32'h81);
		rdChk(OFS_OUTPUT, 32'h7e);
		wrReg(OFS_DIRECTION, 32'h8f); // via tri-state to output low
		check({24'h0, pinOe}, 32'h8f);
		wrReg(OFS_DIRECTION, 32'h0f);
		wbSel <= 4'h0;
		wrReg(OFS_DIRECTION, 32'hff);
		wbSel <= 4'h1;
		rdChk(OFS_DIRECTION, 32'h0f);
		wrReg(8'h20, 32'hff);
		rdChk(8'h20, 32'h0);
		@(posedge core_clk);
		extVal <= 8'hfa;
		#1;
		check({31'h0, pinSample[5]}, 32'h0);
		@(posedge core_clk);
		#1;
		check({31'h0, pinSample[5]}, 32'h1);
		@(posedge core_clk);
		sleepClamp <= 1'b1;
		extIntEnable <= 8'h80;
		extIntEdgeSense <= 8'h40;
		repeat (3) @(posedge core_clk);
		#1;
		check({24'h0, pinSample}, 32'h80);
		@(posedge core_clk);
		sleepClamp <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		check({24'h0, wakeFlag}, 32'h40);
		wrReg(OFS_WAKE_FLAG, 32'h40);
		check({24'h0, wakeFlag}, 32'h0);
		@(posedge core_clk);
		srst <= 1'b1;
		#1;
		check({16'h0, pinOe, pinPullUp}, 32'h0);
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rdChk(OFS_DIRECTION, 32'h0);
		rdChk(OFS_OUTPUT, 32'h0);
		results();
	end
endmodule : tb_top
`default_nettype wire
